// ---- design/uss_core.sv ----
// Purpose: Universal serial shift core, three-wire and two-wire, master or slave
// Assumes: link_clk_in runs freely and oversamples the serial pins
// Notes: Finished bytes reach the system side through a two-entry buffer
`timescale 1ns/1ps
module uss_core
  import uss_pkg::*;
#(
  parameter int BUF_DEPTH_LOG2 = BUF_AW
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic link_clk_in,
  input wire logic wire_mode_in,
  input wire logic [1:0] clk_src_in,
  input wire logic external_edge_select_in,
  input wire logic stretch_en_in,
  input wire logic ovf_ie_in,
  input wire logic start_ie_in,
  input wire logic timer_match_in,
  input wire logic sw_clock_strobe_in,
  input wire logic data_wr_in,
  input wire logic [DATA_W-1:0] data_wr_value_in,
  input wire logic cnt_wr_in,
  input wire logic [CNT_W-1:0] cnt_wr_value_in,
  input wire logic rx_ack_in,
  input wire logic ovf_clear_in,
  input wire logic start_clear_in,
  input wire logic drop_clear_in,
  input wire logic serial_clock_pin_in,
  input wire logic serial_data_in_pin_in,
  output logic [DATA_W-1:0] rx_data_out,
  output logic rx_full_out,
  output logic [CNT_W-1:0] cnt_out,
  output logic ovf_flag_out,
  output logic start_flag_out,
  output logic drop_flag_out,
  output logic ovf_irq_out,
  output logic start_irq_out,
  output logic wake_idle_out,
  output logic wake_deep_out,
  output logic data_out_pin_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic scl_out,
  output logic scl_oe_out
);
  typedef struct packed {
    logic tick_tog;
    logic data_tog;
    logic cnt_tog;
    logic [DATA_W-1:0] ld_data;
    logic [CNT_W-1:0] ld_cnt;
    logic hold_req;
    logic start_s1;
    logic start_s2;
    logic start_d;
    logic drop_s1;
    logic drop_s2;
    logic drop_d;
    logic [CNT_W-1:0] cnt_s1;
    logic [CNT_W-1:0] cnt_s2;
    logic [CNT_W-1:0] cnt;
    logic [DATA_W-1:0] rx_data;
    logic rx_full;
    logic ovf_flag;
    logic start_flag;
    logic drop_flag;
    logic ovf_irq;
    logic start_irq;
    logic wake_idle;
    logic wake_deep;
  } uss_sys_t;

  typedef struct packed {
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic din_s1;
    logic din_s2;
    logic din_d;
    logic tick_s1;
    logic tick_s2;
    logic tick_d;
    logic data_s1;
    logic data_s2;
    logic data_d;
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_d;
    logic hold_s1;
    logic hold_s2;
    logic [DATA_W-1:0] shreg;
    logic sample;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] cnt_gray;
    logic out_latch;
    logic start_tog;
    logic drop_tog;
    logic push;
    logic [DATA_W-1:0] push_data;
    logic do_pin;
    logic sda_o;
    logic sda_oe;
    logic scl_o;
    logic scl_oe;
  } uss_link_t;

  uss_sys_t s, next_s;
  uss_link_t l, next_l;
  logic buf_wr_ready;
  logic buf_rd_valid;
  logic [DATA_W-1:0] buf_rd_data;

  // Link side pushes completed bytes; system side pops only when rx is free
  uss_cdc_buf #(
    .WIDTH(DATA_W),
    .AW(BUF_DEPTH_LOG2)
  ) u_buf (
    .wr_clk_in(link_clk_in),
    .wr_reset_n_in(reset_n_in),
    .wr_valid_in(l.push),
    .wr_data_in(l.push_data),
    .wr_ready_out(buf_wr_ready),
    .rd_clk_in(clk_in),
    .rd_reset_n_in(reset_n_in),
    .rd_ready_in(!s.rx_full),
    .rd_valid_out(buf_rd_valid),
    .rd_data_out(buf_rd_data)
  );

  // System clock domain
  always_comb begin
    logic tick_ev;
    logic pop;
    logic start_ev;
    logic drop_ev;
    tick_ev = 1'h0;
    pop = 1'h0;
    start_ev = 1'h0;
    drop_ev = 1'h0;
    next_s = s;
    case (clk_src_in)
      SRC_TIMER: tick_ev = timer_match_in;
      SRC_SOFT: tick_ev = sw_clock_strobe_in;
      default: tick_ev = 1'h0;
    endcase
    if (tick_ev) begin
      next_s.tick_tog = !s.tick_tog;
    end
    // Held values stay stable while the toggle crosses
    if (data_wr_in) begin
      next_s.ld_data = data_wr_value_in;
      next_s.data_tog = !s.data_tog;
    end
    if (cnt_wr_in) begin
      next_s.ld_cnt = cnt_wr_value_in;
      next_s.cnt_tog = !s.cnt_tog;
    end
    next_s.start_s1 = l.start_tog;
    next_s.start_s2 = s.start_s1;
    next_s.start_d = s.start_s2;
    start_ev = s.start_s2 ^ s.start_d;
    next_s.drop_s1 = l.drop_tog;
    next_s.drop_s2 = s.drop_s1;
    next_s.drop_d = s.drop_s2;
    drop_ev = s.drop_s2 ^ s.drop_d;
    next_s.cnt_s1 = l.cnt_gray;
    next_s.cnt_s2 = s.cnt_s1;
    next_s.cnt = uss_gray2bin(s.cnt_s2);
    pop = buf_rd_valid && !s.rx_full;
    if (rx_ack_in) begin
      next_s.rx_full = 1'h0;
    end
    if (pop) begin
      next_s.rx_full = 1'h1;
      next_s.rx_data = buf_rd_data;
    end
    // Sticky flags: a set in the clearing cycle wins
    if (ovf_clear_in) begin
      next_s.ovf_flag = 1'h0;
    end
    if (pop) begin
      next_s.ovf_flag = 1'h1;
    end
    if (start_clear_in) begin
      next_s.start_flag = 1'h0;
    end
    if (start_ev) begin
      next_s.start_flag = 1'h1;
    end
    if (drop_clear_in) begin
      next_s.drop_flag = 1'h0;
    end
    if (drop_ev) begin
      next_s.drop_flag = 1'h1;
    end
    next_s.hold_req = next_s.ovf_flag || next_s.start_flag;
    next_s.ovf_irq = next_s.ovf_flag && ovf_ie_in;
    next_s.start_irq = next_s.start_flag && start_ie_in;
    next_s.wake_idle = next_s.ovf_irq || next_s.start_irq;
    next_s.wake_deep = next_s.wake_idle && (wire_mode_in == WIRE_TWO);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Link clock domain
  always_comb begin
    logic two_wire;
    logic [1:0] src;
    logic edge_sel;
    logic stretch;
    logic rise;
    logic fall;
    logic tick_ev;
    logic samp;
    logic shft;
    two_wire = l.cfg_s2[CFG_TWO];
    src = l.cfg_s2[CFG_SRC_LO +: 2];
    edge_sel = l.cfg_s2[CFG_EDGE];
    stretch = l.cfg_s2[CFG_STRETCH];
    rise = l.scl_s2 && !l.scl_d;
    fall = !l.scl_s2 && l.scl_d;
    tick_ev = l.tick_s2 ^ l.tick_d;
    samp = 1'h0;
    shft = 1'h0;
    next_l = l;
    next_l.cfg_s1 = {wire_mode_in, clk_src_in, external_edge_select_in, stretch_en_in};
    next_l.cfg_s2 = l.cfg_s1;
    next_l.scl_s1 = serial_clock_pin_in;
    next_l.scl_s2 = l.scl_s1;
    next_l.scl_d = l.scl_s2;
    next_l.din_s1 = serial_data_in_pin_in;
    next_l.din_s2 = l.din_s1;
    next_l.din_d = l.din_s2;
    next_l.tick_s1 = s.tick_tog;
    next_l.tick_s2 = l.tick_s1;
    next_l.tick_d = l.tick_s2;
    next_l.data_s1 = s.data_tog;
    next_l.data_s2 = l.data_s1;
    next_l.data_d = l.data_s2;
    next_l.cnt_s1 = s.cnt_tog;
    next_l.cnt_s2 = l.cnt_s1;
    next_l.cnt_d = l.cnt_s2;
    next_l.hold_s1 = s.hold_req;
    next_l.hold_s2 = l.hold_s1;
    next_l.push = 1'h0;
    if (src == SRC_EXT) begin
      samp = (edge_sel == EDGE_MODE0) ? rise : fall;
      shft = (edge_sel == EDGE_MODE0) ? fall : rise;
    end else begin
      // Internal ticks alternate sample and shift, so sixteen ticks make a byte
      samp = tick_ev && !l.cnt[0];
      shft = tick_ev && l.cnt[0];
    end
    if (samp) begin
      next_l.sample = l.din_s2;
    end
    if (shft) begin
      next_l.shreg = {l.shreg[DATA_W-2:0], l.sample};
      next_l.out_latch = l.shreg[DATA_W-2];
    end
    if (samp || shft) begin
      next_l.cnt = CNT_W'(l.cnt + 1'h1);
      if (l.cnt == CNT_MAX) begin
        // Wrap to zero carries the byte out; a full buffer loses it
        next_l.push = buf_wr_ready;
        next_l.push_data = next_l.shreg;
        if (!buf_wr_ready) begin
          next_l.drop_tog = !l.drop_tog;
        end
      end
    end
    if (l.data_s2 ^ l.data_d) begin
      next_l.shreg = s.ld_data;
      next_l.out_latch = s.ld_data[DATA_W-1];
    end
    if (l.cnt_s2 ^ l.cnt_d) begin
      next_l.cnt = s.ld_cnt;
    end
    if (two_wire && l.scl_s2 && l.scl_d && l.din_d && !l.din_s2) begin
      next_l.start_tog = !l.start_tog;
    end
    next_l.cnt_gray = uss_bin2gray(next_l.cnt);
    // Mode picks the pin that carries the MSB
    next_l.do_pin = (two_wire == WIRE_THREE) && next_l.out_latch;
    next_l.sda_o = 1'h0;
    next_l.sda_oe = two_wire && !next_l.out_latch;
    next_l.scl_o = 1'h0;
    next_l.scl_oe = two_wire && stretch && (l.hold_s2 || !buf_wr_ready);
  end

  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign rx_data_out = s.rx_data;
  assign rx_full_out = s.rx_full;
  assign cnt_out = s.cnt;
  assign ovf_flag_out = s.ovf_flag;
  assign start_flag_out = s.start_flag;
  assign drop_flag_out = s.drop_flag;
  assign ovf_irq_out = s.ovf_irq;
  assign start_irq_out = s.start_irq;
  assign wake_idle_out = s.wake_idle;
  assign wake_deep_out = s.wake_deep;
  assign data_out_pin_out = l.do_pin;
  assign sda_out = l.sda_o;
  assign sda_oe_out = l.sda_oe;
  assign scl_out = l.scl_o;
  assign scl_oe_out = l.scl_oe;
endmodule : uss_core

// ---- design/uss_pkg.sv ----
// Purpose: Shared constants and helpers for the universal serial shift core
// Assumes: System clock clk_in at 20 MHz, link logic on its own clock
// Notes: Configuration inputs are quasi-static; change them only between frames
package uss_pkg;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int BUF_AW = 1;
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_SOFT = 2'h2;
  localparam logic WIRE_THREE = 1'h0;
  localparam logic WIRE_TWO = 1'h1;
  localparam logic EDGE_MODE0 = 1'h0;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam logic [3:0] CNT_RESET = 4'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam int CFG_W = 5;
  localparam int CFG_TWO = 4;
  localparam int CFG_SRC_LO = 2;
  localparam int CFG_EDGE = 1;
  localparam int CFG_STRETCH = 0;

  function automatic logic [3:0] uss_bin2gray(input logic [3:0] b);
    return b ^ (b >> 1);
  endfunction : uss_bin2gray

  function automatic logic [3:0] uss_gray2bin(input logic [3:0] g);
    logic [3:0] b;
    b = g;
    for (int i = 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : uss_gray2bin
endpackage : uss_pkg

// ---- design/uss_cdc_buf.sv ----
// Purpose: Two-entry dual-clock buffer carrying finished bytes to the system side
// Assumes: Gray-coded pointers, each synchronised by two flip-flops
// Notes: Depth is 2**AW; full and empty are conservative by the sync delay
`timescale 1ns/1ps
module uss_cdc_buf #(
  parameter int WIDTH = 8,
  parameter int AW = 1
) (
  input wire logic wr_clk_in,
  input wire logic wr_reset_n_in,
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  input wire logic rd_clk_in,
  input wire logic rd_reset_n_in,
  input wire logic rd_ready_in,
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH = PW'(2 ** AW);

  typedef struct packed {
    logic [PW-1:0] ptr;
    logic [PW-1:0] gray;
    logic [PW-1:0] s1;
    logic [PW-1:0] s2;
  } uss_side_t;

  uss_side_t w, next_w, r, next_r;
  logic [WIDTH-1:0] mem [0:(2**AW)-1];

  function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction : g2b

  assign wr_ready_out = (PW'(w.ptr - g2b(w.s2)) != DEPTH);
  assign rd_valid_out = (r.ptr != g2b(r.s2));
  assign rd_data_out = mem[r.ptr[AW-1:0]];

  always_comb begin
    next_w = w;
    next_w.s1 = r.gray;
    next_w.s2 = w.s1;
    if (wr_valid_in && wr_ready_out) begin
      next_w.ptr = PW'(w.ptr + 1'h1);
    end
    next_w.gray = next_w.ptr ^ (next_w.ptr >> 1);
  end

  always_comb begin
    next_r = r;
    next_r.s1 = w.gray;
    next_r.s2 = r.s1;
    if (rd_valid_out && rd_ready_in) begin
      next_r.ptr = PW'(r.ptr + 1'h1);
    end
    next_r.gray = next_r.ptr ^ (next_r.ptr >> 1);
  end

  always_ff @(posedge wr_clk_in or negedge wr_reset_n_in) begin
    if (!wr_reset_n_in) begin
      w <= '0;
    end else begin
      w <= next_w;
    end
  end

  // Storage needs no reset; empty guards every read
  always_ff @(posedge wr_clk_in) begin
    if (wr_valid_in && wr_ready_out) begin
      mem[w.ptr[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge rd_clk_in or negedge rd_reset_n_in) begin
    if (!rd_reset_n_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : uss_cdc_buf

// ---- verif/uss_asserts.sv ----
// Purpose: Port checks for the serial shift core
// Assumes: Configuration levels are quasi-static
// Notes: System clock domain only; link lag is covered by repetition
`timescale 1ns/1ps
module uss_asserts
  import uss_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wire_mode_in,
  input wire logic stretch_en_in,
  input wire logic ovf_ie_in,
  input wire logic start_ie_in,
  input wire logic ovf_clear_in,
  input wire logic rx_ack_in,
  input wire logic [DATA_W-1:0] rx_data_out,
  input wire logic rx_full_out,
  input wire logic ovf_flag_out,
  input wire logic start_flag_out,
  input wire logic ovf_irq_out,
  input wire logic start_irq_out,
  input wire logic wake_idle_out,
  input wire logic wake_deep_out,
  input wire logic data_out_pin_out,
  input wire logic sda_oe_out,
  input wire logic scl_oe_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_ovf_irq_set: assert property ((ovf_flag_out && ovf_ie_in) [*2] |-> ovf_irq_out)
    else $error("overflow interrupt missing");
  a_ovf_irq_quiet: assert property (!ovf_flag_out && !$past(ovf_flag_out) |-> !ovf_irq_out)
    else $error("overflow interrupt without flag");
  a_start_irq_set: assert property ((start_flag_out && start_ie_in) [*2] |-> start_irq_out)
    else $error("start interrupt missing");
  a_ovf_sticky: assert property (ovf_flag_out && !ovf_clear_in |=> ovf_flag_out)
    else $error("overflow flag lost without clear");
  a_push_flags: assert property ($rose(rx_full_out) |-> ovf_flag_out)
    else $error("byte arrived without overflow flag");
  a_rx_hold: assert property (rx_full_out && !rx_ack_in |=> rx_full_out && $stable(rx_data_out))
    else $error("received byte changed before ack");
  a_wake_idle: assert property ((ovf_irq_out || start_irq_out) [*2] |-> wake_idle_out)
    else $error("idle wake missing");
  a_wake_deep: assert property ((wake_idle_out && wire_mode_in == WIRE_TWO) [*2] |-> wake_deep_out)
    else $error("deep wake missing");
  a_three_oe: assert property ((wire_mode_in == WIRE_THREE) [*3] |-> !sda_oe_out && !scl_oe_out)
    else $error("two-wire drivers on in three-wire mode");
  a_two_pin: assert property ((wire_mode_in == WIRE_TWO) [*3] |-> !data_out_pin_out)
    else $error("three-wire pin driven in two-wire mode");
  // Three cycles leave room for the flag to cross into the link domain
  a_scl_stretch: assert property ((start_flag_out && stretch_en_in && wire_mode_in) [*3] |-> scl_oe_out)
    else $error("clock not held after start");
endmodule : uss_asserts

// ---- verif/uss_peer.sv ----
// Purpose: Three-wire master peer for the serial shift core
// Assumes: Edge mode 0, clock idles low between frames
// Notes: Half period is half_in plus one link clocks; released data line shows the inverse
`timescale 1ns/1ps
module uss_peer (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [4:0] half_in,
  input wire logic [7:0] tx_in,
  input wire logic miso_in,
  output logic sck_out,
  output logic mosi_out,
  output logic [7:0] rx_out,
  output logic busy_out
);
  logic [4:0] dly = 5'h00;
  logic [4:0] edges = 5'h00;
  logic [7:0] sh = 8'h00;
  initial begin
    sck_out = 1'h0;
    mosi_out = 1'h0;
    rx_out = 8'h00;
    busy_out = 1'h0;
  end
  always @(posedge clk_in) begin
    if (!busy_out && go_in) begin
      busy_out <= 1'h1;
      edges <= 5'h00;
      dly <= half_in;
      sh <= tx_in;
      mosi_out <= tx_in[7];
    end else if (busy_out && dly != 5'h00) begin
      dly <= dly - 5'h01;
    end else if (busy_out && edges == 5'h10) begin
      busy_out <= 1'h0;
      mosi_out <= ~mosi_out;
    end else if (busy_out) begin
      dly <= half_in;
      edges <= edges + 5'h01;
      sck_out <= ~sck_out;
      if (!sck_out) begin
        rx_out <= {rx_out[6:0], miso_in};
      end else begin
        mosi_out <= sh[6];
        sh <= {sh[6:0], 1'h0};
      end
    end
  end
endmodule : uss_peer

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the serial shift core
// Assumes: Peer is a three-wire master whose own clock idles low
// Notes: Edge mode 1 runs with the peer clock inverted, so the pin idles high
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import uss_pkg::*;
  logic clk_in = 1'h0;
  logic link_clk = 1'h0;
  logic reset_n = 1'h0;
  logic wire_mode = WIRE_THREE;
  logic [1:0] clk_src = SRC_EXT;
  logic stretch = 1'h0, ovf_ie = 1'h1, start_ie = 1'h0, tmr = 1'h0, sws = 1'h0;
  logic dwr = 1'h0, cwr = 1'h0, ack = 1'h0, oclr = 1'h0, sclr = 1'h0, dclr = 1'h0;
  logic tb_scl = 1'h1, tb_sda = 1'h1, go = 1'h0;
  logic [7:0] dval = 8'h00, ptx = 8'h00, prx, rx_data;
  logic [3:0] cval = 4'h0, cnt;
  logic [4:0] half = 5'h08;
  logic rx_full, ovf, stf, drf, oirq, sirq, wki, wkd, dpin, sda_oe, scl_oe, p_sck, p_mosi, busy;
  logic edge_mode = EDGE_MODE0;
  logic sda_o, scl_o;
  int checks = 0, n_mismatch = 0, cyc = 0;
  // Open-drain wires pulled high; an enabled driver shows its own level
  wire logic sck_w = wire_mode ? (tb_scl & (scl_oe ? scl_o : 1'h1)) : (p_sck ^ edge_mode);
  wire logic sdi_w = wire_mode ? (tb_sda & (sda_oe ? sda_o : 1'h1)) : p_mosi;
  always #25 clk_in = ~clk_in;
  initial begin
    #1.7;
    forever #3 link_clk = ~link_clk;
  end
  uss_core u_dut (
    .clk_in(clk_in), .reset_n_in(reset_n), .link_clk_in(link_clk), .wire_mode_in(wire_mode),
    .clk_src_in(clk_src), .external_edge_select_in(edge_mode), .stretch_en_in(stretch),
    .ovf_ie_in(ovf_ie), .start_ie_in(start_ie), .timer_match_in(tmr), .sw_clock_strobe_in(sws),
    .data_wr_in(dwr), .data_wr_value_in(dval), .cnt_wr_in(cwr), .cnt_wr_value_in(cval),
    .rx_ack_in(ack), .ovf_clear_in(oclr), .start_clear_in(sclr), .drop_clear_in(dclr),
    .serial_clock_pin_in(sck_w), .serial_data_in_pin_in(sdi_w), .rx_data_out(rx_data),
    .rx_full_out(rx_full), .cnt_out(cnt), .ovf_flag_out(ovf), .start_flag_out(stf),
    .drop_flag_out(drf), .ovf_irq_out(oirq), .start_irq_out(sirq), .wake_idle_out(wki),
    .wake_deep_out(wkd), .data_out_pin_out(dpin), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .scl_out(scl_o), .scl_oe_out(scl_oe));
  uss_peer u_peer (.clk_in(link_clk), .go_in(go), .half_in(half), .tx_in(ptx),
    .miso_in(dpin), .sck_out(p_sck), .mosi_out(p_mosi), .rx_out(prx), .busy_out(busy));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick
  // d high loads the shift register, low loads the counter
  task automatic wr(input logic d, input logic [7:0] v);
    tick(1);
    dwr <= d;
    cwr <= ~d;
    dval <= v;
    cval <= v[3:0];
    tick(1);
    dwr <= 1'h0;
    cwr <= 1'h0;
    tick(3);
    @(negedge clk_in);
  endtask : wr
  task automatic clr(input logic [3:0] m);
    tick(1);
    {ack, oclr, sclr, dclr} <= m;
    tick(1);
    {ack, oclr, sclr, dclr} <= 4'h0;
    tick(4);
    @(negedge clk_in);
  endtask : clr
  // Three cycles apart so the link sees every tick
  task automatic pulses(input int n, input logic t);
    repeat (n) begin
      tick(1);
      tmr <= t;
      sws <= ~t;
      tick(1);
      tmr <= 1'h0;
      sws <= 1'h0;
      tick(1);
    end
  endtask : pulses
  task automatic t_spi(input logic m, input logic [4:0] h, input logic [7:0] mine,
      input logic [7:0] peer);
    tick(1);
    // A mode change may move the pin; the counter write below discards that edge
    edge_mode <= m;
    wr(1'h0, 8'h00);
    wr(1'h1, mine);
    `CHK(dpin, mine[7])
    tick(1);
    half <= h;
    ptx <= peer;
    go <= 1'h1;
    wait (busy);
    tick(1);
    go <= 1'h0;
    wait (!busy);
    tick(8);
    @(negedge clk_in);
    `CHK(prx, mine)
    `CHK(rx_data, peer)
    `CHK(cnt, 4'h0)
    `CHK({rx_full, ovf, oirq, wki, wkd}, 5'h1E)
    clr(4'hC);
    `CHK({rx_full, ovf, oirq}, 3'h0)
  endtask : t_spi
  task automatic t_cnt;
    tick(1);
    clk_src <= SRC_SOFT;
    wr(1'h0, 8'h00);
    pulses(3, 1'h0);
    pulses(2, 1'h1);
    tick(4);
    @(negedge clk_in);
    `CHK(cnt, 4'h3)
    tick(1);
    clk_src <= SRC_TIMER;
    wr(1'h0, 8'h0E);
    pulses(2, 1'h1);
    tick(8);
    @(negedge clk_in);
    `CHK({cnt, rx_full, ovf}, 6'h03)
    clr(4'hC);
  endtask : t_cnt
  task automatic t_drop;
    tick(1);
    clk_src <= SRC_SOFT;
    pulses(64, 1'h0);
    tick(8);
    @(negedge clk_in);
    `CHK({rx_full, drf}, 2'h3)
    for (int i = 2; i >= 0; i--) begin
      clr(4'h8);
      `CHK(rx_full, 1'(i != 0))
    end
    clr(4'h5);
    `CHK({ovf, drf}, 2'h0)
  endtask : t_drop
  task automatic t_twi;
    tick(1);
    wire_mode <= WIRE_TWO;
    stretch <= 1'h1;
    start_ie <= 1'h1;
    wr(1'h1, 8'h00);
    `CHK({sda_oe, dpin}, 2'h2)
    // Own low MSB pulls the data line down under a high clock: a start
    `CHK(stf, 1'h1)
    wr(1'h1, 8'h80);
    `CHK(sda_oe, 1'h0)
    clr(4'h2);
    `CHK({stf, scl_oe}, 2'h0)
    tick(1);
    tb_sda <= 1'h0;
    tick(6);
    @(negedge clk_in);
    `CHK({stf, sirq, wkd, scl_oe}, 4'hF)
    clr(4'h2);
    `CHK({stf, scl_oe}, 2'h0)
  endtask : t_twi
  task automatic close_out;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    tick(5);
    reset_n <= 1'h1;
    tick(2);
    @(negedge clk_in);
    `CHK({rx_full, ovf, stf, drf, cnt, scl_oe}, 9'h000)
    t_spi(1'h0, 5'h08, 8'hA5, 8'h3C);
    t_spi(1'h1, 5'h19, 8'h5A, 8'hC3);
    t_cnt();
    t_drop();
    t_twi();
    close_out();
  end
endmodule : testbench
bind uss_core uss_asserts u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .wire_mode_in(wire_mode_in), .stretch_en_in(stretch_en_in), .ovf_ie_in(ovf_ie_in),
  .start_ie_in(start_ie_in), .ovf_clear_in(ovf_clear_in), .rx_ack_in(rx_ack_in),
  .rx_data_out(rx_data_out), .rx_full_out(rx_full_out), .ovf_flag_out(ovf_flag_out),
  .start_flag_out(start_flag_out), .ovf_irq_out(ovf_irq_out), .start_irq_out(start_irq_out),
  .wake_idle_out(wake_idle_out), .wake_deep_out(wake_deep_out),
  .data_out_pin_out(data_out_pin_out), .sda_oe_out(sda_oe_out), .scl_oe_out(scl_oe_out));
